/* File: core/csd_defines.svh */
// Purpose: addresses, field positions, reset values and timing counts of the clock selector
// Assumes: included by bare name; definitions only
// Notes: every offset is a full byte address on the APB
`ifndef CSD_DEFINES_SVH
`define CSD_DEFINES_SVH

// Register byte addresses
`define CSD_ADDR_SPLL_SEL 32'h40048040
`define CSD_ADDR_SPLL_UPD 32'h40048044
`define CSD_ADDR_USB_SEL 32'h40048048
`define CSD_ADDR_USB_UPD 32'h4004804c
`define CSD_ADDR_MAIN_SEL 32'h40048070
`define CSD_ADDR_MAIN_UPD 32'h40048074
`define CSD_ADDR_RATIO 32'h40048078
`define CSD_ADDR_STATUS 32'h400480fc

// Field positions and widths
`define CSD_SEL_W 2
`define CSD_UPD_BIT 0
`define CSD_RATIO_W 8

// Reset values
`define CSD_RST_SPLL_SEL 2'h0
`define CSD_RST_SPLL_UPD 1'h1
`define CSD_RST_USB_SEL 2'h0
`define CSD_RST_USB_UPD 1'h0
`define CSD_RST_MAIN_SEL 2'h0
`define CSD_RST_MAIN_UPD 1'h1
`define CSD_RST_RATIO 8'h01

// Timing: APB answer comes in the first access cycle
`define CSD_APB_WAIT_CYCLES 0

`endif

/* File: core/csd_pkg.sv */
// Purpose: types shared by the clock selector and its switch cells
// Assumes: nothing outside this package
// Notes: constants live in csd_defines.svh
package csd_pkg;

  typedef logic [1:0] csd_sel_t;

  typedef enum logic [0:0] {CSD_SW_RUN, CSD_SW_PARK} csd_sw_state_e;

  // APB request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } csd_apb_req_s;

  // Clock sources, sampled as plain levels
  typedef struct packed {
    logic internal_rc_oscillator;
    logic xtal;
    logic wdt;
    logic rtc32k;
    logic spll_out;
  } csd_osc_s;

  // State of one glitch-free switch
  typedef struct packed {
    csd_sw_state_e state;
    csd_sel_t sel;
    csd_sel_t next_sel;
    logic pending;
    logic clk;
  } csd_sw_s;

  // State of the top level
  typedef struct packed {
    csd_sel_t spll_sel;
    logic spll_upd;
    csd_sel_t usb_sel;
    logic usb_upd;
    csd_sel_t main_sel;
    logic main_upd;
    logic [7:0] ratio;
    logic [7:0] cnt;
    logic main_prev;
    logic sys_clk;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } csd_top_s;

endpackage : csd_pkg

/* File: core/csd_clk_switch.sv */
// Purpose: glitch-free four-way clock switch working on sampled clock levels
// Assumes: sources run well below half of sys_clk; old and new source both running
// Notes: parks the output low between the two sources
`timescale 1ns/1ps
`default_nettype none
module csd_clk_switch #(
  parameter csd_pkg::csd_sel_t RST_SEL = 2'h0
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [3:0] src_lvl,
  input wire logic req,
  input wire csd_pkg::csd_sel_t req_sel,
  output logic clk_o,
  output csd_pkg::csd_sel_t sel_o,
  output logic busy_o
);
  import csd_pkg::*;

  csd_sw_s q;
  csd_sw_s d;

  // Leave old source only while low, join new one only while low
  always_comb
  begin
    d = q;
    if (req)
    begin
      d.next_sel = req_sel;
      d.pending = 1'b1;
    end
    unique case (q.state)
      CSD_SW_RUN:
      begin
        d.clk = src_lvl[q.sel];
        if (q.pending && !q.clk && !src_lvl[q.sel]) // RULE14
        begin
          d.state = CSD_SW_PARK;
          d.clk = 1'b0;
        end
      end
      CSD_SW_PARK:
      begin
        d.clk = 1'b0;
        if (!src_lvl[q.next_sel]) // RULE14
        begin
          d.sel = q.next_sel;
          d.pending = req;
          d.state = CSD_SW_RUN;
        end
      end
    endcase
  end

  // All state frozen while the enable is low
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= '{state: CSD_SW_RUN, sel: RST_SEL, next_sel: RST_SEL, pending: 1'b0, clk: 1'b0};
    else if (clk_en)
      q <= d;
  end

  assign clk_o = q.clk;
  assign sel_o = q.sel;
  assign busy_o = q.pending | (q.state == CSD_SW_PARK);

  property p_park_low;
    @(posedge sys_clk) disable iff (!rst_n)
    (q.state == CSD_SW_PARK) && clk_en |=> !clk_o;
  endproperty
  a_park_low: assert property (p_park_low) // RULE14
    else $error("switch output high while parked");

  property p_sel_needs_req;
    @(posedge sys_clk) disable iff (!rst_n)
    $changed(sel_o) |-> $past(q.pending) && $past(q.state == CSD_SW_PARK);
  endproperty
  a_sel_needs_req: assert property (p_sel_needs_req) // RULE14
    else $error("source changed without update");

  property p_follow_src;
    @(posedge sys_clk) disable iff (!rst_n)
    clk_en && (q.state == CSD_SW_RUN) && !q.pending |=> clk_o == $past(src_lvl[q.sel]);
  endproperty
  a_follow_src: assert property (p_follow_src) // RULE14
    else $error("output does not follow chosen source");

endmodule : csd_clk_switch
`default_nettype wire

/* File: core/csd_clock_control.sv */
// Purpose: source selectors and system clock divider with an APB register file
// Assumes: source clocks are levels synchronous to sys_clk and slower than sys_clk/2
// Notes: zero-wait APB slave; unmapped addresses answer with pslverr
`timescale 1ns/1ps
`default_nettype none
`include "csd_defines.svh"

// Notes on behaviour
// RULE1: PLL source code 0 internal oscillator, 1 crystal, 3 32 kHz; 2 reserved.
// RULE2: The chosen PLL source also feeds the main selector as PLL-input option.
// RULE3: Software uses 32 kHz only through PLL-input, never as real PLL reference.
// RULE4: New PLL source takes effect only after update bit written zero then one.
// RULE5: USB PLL source code 0 internal oscillator, 1 crystal; codes 2 and 3 reserved.
// RULE6: Software picks the crystal for full-speed USB; internal oscillator only low-speed.
// RULE7: New USB PLL source applies only after its update bit written zero then one. The bit resets to zero, so a first lone write of one applies it.
// RULE8: Software keeps old and new clocks running before triggering any source update.
// RULE9: Software moves USB reference to crystal while both run, then stops oscillator.
// RULE10: Main code 0 internal oscillator, 1 PLL input, 2 watchdog, 3 PLL output.
// RULE11: New main source applies only after its update bit written zero then one.
// RULE12: System clock is main clock divided by ratio; ratio zero stops it.
// RULE13: Divided system clock drives core, peripherals and memories.
// RULE14: Each selector changes only on update rising edge, glitch-free between running clocks.
module csd_clock_control (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire csd_pkg::csd_apb_req_s apb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire csd_pkg::csd_osc_s osc,
  output logic sys_pll_ref_o,
  output logic usb_pll_ref_o,
  output logic main_clk_o,
  output logic core_clk_o,
  output logic periph_clk_o,
  output logic mem_clk_o
);
  import csd_pkg::*;

  csd_top_s q;
  csd_top_s d;
  logic setup;
  logic wr_acc;
  logic spll_req;
  logic usb_req;
  logic main_req;
  logic main_rise;
  logic spll_busy;
  logic usb_busy;
  logic main_busy;
  csd_sel_t spll_act;
  csd_sel_t usb_act;
  csd_sel_t main_act;
  logic [3:0] spll_src;
  logic [3:0] usb_src;
  logic [3:0] main_src;

  // Address decode, used by the error answer and the APB answer assertion
  function automatic logic csd_mapped(input logic [31:0] addr);
    csd_mapped = (addr == `CSD_ADDR_SPLL_SEL) || (addr == `CSD_ADDR_SPLL_UPD) ||
                 (addr == `CSD_ADDR_USB_SEL) || (addr == `CSD_ADDR_USB_UPD) ||
                 (addr == `CSD_ADDR_MAIN_SEL) || (addr == `CSD_ADDR_MAIN_UPD) ||
                 (addr == `CSD_ADDR_RATIO) || (addr == `CSD_ADDR_STATUS);
  endfunction : csd_mapped

  // Zero-to-one write on an update bit; a write of zero gives no strobe
  function automatic logic csd_upd_rise(input logic hit, input logic old_bit,
                                         input logic [31:0] wdata);
    csd_upd_rise = hit && !old_bit && wdata[`CSD_UPD_BIT];
  endfunction : csd_upd_rise

  // Half-period threshold: high for the first ceil(ratio/2) main periods
  function automatic logic csd_div_high(input logic [7:0] cnt, input logic [7:0] ratio);
    logic [8:0] half;
    half = ({1'b0, ratio} + 9'h001) >> 1;
    csd_div_high = {1'b0, cnt} < half;
  endfunction : csd_div_high

  // Source wiring; reserved codes route a constant low
  assign spll_src = {osc.rtc32k, 1'b0, osc.xtal, osc.internal_rc_oscillator}; // RULE1
  assign usb_src = {1'b0, 1'b0, osc.xtal, osc.internal_rc_oscillator}; // RULE5
  assign main_src = {osc.spll_out, osc.wdt, sys_pll_ref_o, osc.internal_rc_oscillator}; // RULE2 RULE10

  // APB phases; writes land only in the access cycle with pready high
  assign setup = apb.psel && !apb.penable;
  assign wr_acc = apb.psel && apb.penable && apb.pwrite && q.pready && !q.pslverr;

  // Update strobes fire only on a zero-to-one write
  assign spll_req = csd_upd_rise(wr_acc && (apb.paddr == `CSD_ADDR_SPLL_UPD),
                                 q.spll_upd, apb.pwdata); // RULE4
  assign usb_req = csd_upd_rise(wr_acc && (apb.paddr == `CSD_ADDR_USB_UPD),
                                q.usb_upd, apb.pwdata); // RULE7
  assign main_req = csd_upd_rise(wr_acc && (apb.paddr == `CSD_ADDR_MAIN_UPD),
                                 q.main_upd, apb.pwdata); // RULE11

  assign main_rise = main_clk_o && !q.main_prev;

  // System PLL reference selector
  csd_clk_switch #(
    .RST_SEL(`CSD_RST_SPLL_SEL)
  ) u_spll_sw (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .src_lvl(spll_src),
    .req(spll_req),
    .req_sel(q.spll_sel),
    .clk_o(sys_pll_ref_o),
    .sel_o(spll_act),
    .busy_o(spll_busy)
  );

  // USB PLL reference selector
  csd_clk_switch #(
    .RST_SEL(`CSD_RST_USB_SEL)
  ) u_usb_sw (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .src_lvl(usb_src),
    .req(usb_req),
    .req_sel(q.usb_sel),
    .clk_o(usb_pll_ref_o),
    .sel_o(usb_act),
    .busy_o(usb_busy)
  );

  // Main clock selector
  csd_clk_switch #(
    .RST_SEL(`CSD_RST_MAIN_SEL)
  ) u_main_sw (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .src_lvl(main_src),
    .req(main_req),
    .req_sel(q.main_sel),
    .clk_o(main_clk_o),
    .sel_o(main_act),
    .busy_o(main_busy)
  );

  // Register file, APB answer and divider
  always_comb
  begin
    d = q;
    d.pready = setup;
    d.pslverr = setup && !csd_mapped(apb.paddr);
    d.prdata = 32'h00000000;
    if (setup && !apb.pwrite)
    begin
      unique case (apb.paddr)
        `CSD_ADDR_SPLL_SEL: d.prdata = {30'h0, q.spll_sel};
        `CSD_ADDR_SPLL_UPD: d.prdata = {31'h0, q.spll_upd};
        `CSD_ADDR_USB_SEL: d.prdata = {30'h0, q.usb_sel};
        `CSD_ADDR_USB_UPD: d.prdata = {31'h0, q.usb_upd};
        `CSD_ADDR_MAIN_SEL: d.prdata = {30'h0, q.main_sel};
        `CSD_ADDR_MAIN_UPD: d.prdata = {31'h0, q.main_upd};
        `CSD_ADDR_RATIO: d.prdata = {24'h000000, q.ratio};
        `CSD_ADDR_STATUS: d.prdata = {20'h00000, 1'b0, main_busy, usb_busy, spll_busy,
                                      2'h0, main_act, usb_act, spll_act};
        default: d.prdata = 32'h00000000;
      endcase
    end
    // Choice fields only store; the switches take them on the strobe
    if (wr_acc)
    begin
      unique case (apb.paddr)
        `CSD_ADDR_SPLL_SEL: d.spll_sel = apb.pwdata[`CSD_SEL_W-1:0];
        `CSD_ADDR_SPLL_UPD: d.spll_upd = apb.pwdata[`CSD_UPD_BIT];
        `CSD_ADDR_USB_SEL: d.usb_sel = apb.pwdata[`CSD_SEL_W-1:0];
        `CSD_ADDR_USB_UPD: d.usb_upd = apb.pwdata[`CSD_UPD_BIT];
        `CSD_ADDR_MAIN_SEL: d.main_sel = apb.pwdata[`CSD_SEL_W-1:0];
        `CSD_ADDR_MAIN_UPD: d.main_upd = apb.pwdata[`CSD_UPD_BIT];
        `CSD_ADDR_RATIO: d.ratio = apb.pwdata[`CSD_RATIO_W-1:0];
        default: d.ratio = q.ratio;
      endcase
    end
    // Divider counts main rising edges; a shrunk ratio wraps on the next main rising edge
    d.main_prev = main_clk_o;
    if (main_rise)
    begin
      if ((q.ratio == 8'h00) || (q.cnt >= q.ratio - 8'h01))
        d.cnt = 8'h00;
      else
        d.cnt = q.cnt + 8'h01;
    end
    if (q.ratio == 8'h00)
      d.sys_clk = 1'b0; // RULE12
    else if (q.ratio == 8'h01)
      d.sys_clk = main_clk_o; // RULE12
    else
      d.sys_clk = csd_div_high(d.cnt, q.ratio); // RULE12
  end

  // Single state register, frozen while the enable is low
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '0;
      q.spll_sel <= `CSD_RST_SPLL_SEL;
      q.spll_upd <= `CSD_RST_SPLL_UPD;
      q.usb_sel <= `CSD_RST_USB_SEL;
      q.usb_upd <= `CSD_RST_USB_UPD;
      q.main_sel <= `CSD_RST_MAIN_SEL;
      q.main_upd <= `CSD_RST_MAIN_UPD;
      q.ratio <= `CSD_RST_RATIO;
    end
    else if (clk_en)
      q <= d;
  end

  // One divided clock fans out to all three consumers
  assign core_clk_o = q.sys_clk; // RULE13
  assign periph_clk_o = q.sys_clk; // RULE13
  assign mem_clk_o = q.sys_clk; // RULE13
  assign pready = q.pready;
  assign prdata = q.prdata;
  assign pslverr = q.pslverr;

  property p_ratio_zero_stops;
    @(posedge sys_clk) disable iff (!rst_n)
    clk_en && (q.ratio == 8'h00) ##1 (q.ratio == 8'h00) |-> !core_clk_o;
  endproperty
  a_ratio_zero_stops: assert property (p_ratio_zero_stops) // RULE12
    else $error("clock runs at ratio zero");

  property p_ratio_one_passes;
    @(posedge sys_clk) disable iff (!rst_n)
    clk_en && (q.ratio == 8'h01) |=> core_clk_o == $past(main_clk_o);
  endproperty
  a_ratio_one_passes: assert property (p_ratio_one_passes) // RULE12
    else $error("ratio one not pass-through");

  property p_spll_strobe;
    @(posedge sys_clk) disable iff (!rst_n)
    clk_en && spll_req |=> q.spll_upd && spll_busy;
  endproperty
  a_spll_strobe: assert property (p_spll_strobe) // RULE4
    else $error("pll update not pending");

  property p_usb_strobe;
    @(posedge sys_clk) disable iff (!rst_n)
    clk_en && usb_req |=> q.usb_upd && usb_busy;
  endproperty
  a_usb_strobe: assert property (p_usb_strobe) // RULE7
    else $error("usb update not pending");

  property p_main_strobe;
    @(posedge sys_clk) disable iff (!rst_n)
    clk_en && wr_acc && (apb.paddr == `CSD_ADDR_MAIN_UPD) && q.main_upd |-> !main_req;
  endproperty
  a_main_strobe: assert property (p_main_strobe) // RULE11
    else $error("main update on one after one");

  property p_fanout;
    @(posedge sys_clk) disable iff (!rst_n)
    (core_clk_o == periph_clk_o) && (periph_clk_o == mem_clk_o);
  endproperty
  a_fanout: assert property (p_fanout) // RULE13
    else $error("system clock copies differ");

  property p_apb_answer;
    @(posedge sys_clk) disable iff (!rst_n)
    clk_en && setup |=> pready && (pslverr == !$past(csd_mapped(apb.paddr)));
  endproperty
  a_apb_answer: assert property (p_apb_answer)
    else $error("apb answer missing or wrong");

  // Settled selectors pass their source one cycle late; reserved codes stay low
  property p_spll_rsv;
    @(posedge sys_clk) disable iff (!rst_n)
    clk_en && (spll_act == 2'h2) |=> !sys_pll_ref_o;
  endproperty
  a_spll_rsv: assert property (p_spll_rsv) // RULE1
    else $error("pll reference high on reserved code");

  property p_usb_rsv;
    @(posedge sys_clk) disable iff (!rst_n)
    clk_en && usb_act[1] |=> !usb_pll_ref_o;
  endproperty
  a_usb_rsv: assert property (p_usb_rsv) // RULE5
    else $error("usb reference high on reserved code");

  property p_main_pll_in;
    @(posedge sys_clk) disable iff (!rst_n)
    clk_en && (main_act == 2'h1) && !main_busy |=> main_clk_o == $past(sys_pll_ref_o);
  endproperty
  a_main_pll_in: assert property (p_main_pll_in) // RULE2
    else $error("main clock does not follow pll input");

  property p_main_wdt;
    @(posedge sys_clk) disable iff (!rst_n)
    clk_en && (main_act == 2'h2) && !main_busy |=> main_clk_o == $past(osc.wdt);
  endproperty
  a_main_wdt: assert property (p_main_wdt) // RULE10
    else $error("main clock does not follow watchdog source");

  property p_spll_hold;
    @(posedge sys_clk) disable iff (!rst_n)
    clk_en && !spll_busy && !spll_req |=> $stable(spll_act);
  endproperty
  a_spll_hold: assert property (p_spll_hold) // RULE4 RULE14
    else $error("pll source moved without update");

endmodule : csd_clock_control
`default_nettype wire

/* File: test/csd_clock_control_tb_top.sv */
// Purpose: self-checking bench for the clock selectors and the system divider
// Assumes: zero-wait APB slave; slow source levels are made here from sys_clk
// Notes: clocks are judged by rising-edge counts, so a cycle or two of lag is tolerated
`timescale 1ns/1ps
`default_nettype none
`include "csd_defines.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module csd_clock_control_tb_top;
  import csd_pkg::*;
  logic sys_clk;
  logic rst_n;
  logic clk_en;
  csd_apb_req_s apb;
  csd_osc_s osc;
  logic [4:0] osc_v;
  logic pready, pslverr;
  logic [31:0] prdata;
  logic spll_ref, usb_ref, main_clk, core_clk, periph_clk, mem_clk;
  int error_cnt = 0;
  int checked = 0;
  logic [31:0] seed = 32'h00008646;
  int half[5] = '{3, 5, 7, 11, 4};
  int ocnt[5] = '{0, 0, 0, 0, 0};
  int src_e[5];
  int out_e[4];
  logic [31:0] addrs[7] = '{`CSD_ADDR_SPLL_SEL, `CSD_ADDR_SPLL_UPD, `CSD_ADDR_USB_SEL,
    `CSD_ADDR_USB_UPD, `CSD_ADDR_MAIN_SEL, `CSD_ADDR_MAIN_UPD, `CSD_ADDR_RATIO};
  logic [31:0] rstv[7] = '{32'h0, 32'h1, 32'h0, 32'h0, 32'h0, 32'h1, 32'h1};
  logic [31:0] mask[7] = '{32'h3, 32'h1, 32'h3, 32'h1, 32'h3, 32'h1, 32'hff};

  // Source order: irc, xtal, watchdog, 32 kHz, pll output
  assign osc = {osc_v[0], osc_v[1], osc_v[2], osc_v[3], osc_v[4]};

  csd_clock_control dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .apb(apb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .osc(osc),
    .sys_pll_ref_o(spll_ref), .usb_pll_ref_o(usb_ref), .main_clk_o(main_clk),
    .core_clk_o(core_clk), .periph_clk_o(periph_clk), .mem_clk_o(mem_clk));

  // Clock
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // Slow sources; distinct periods so a wrong route shows in the edge count
  always @(posedge sys_clk)
  begin
    for (int i = 0; i < 5; i++)
    begin
      if (ocnt[i] == half[i] - 1)
      begin
        ocnt[i] <= 0;
        osc_v[i] <= ~osc_v[i];
      end
      else
        ocnt[i] <= ocnt[i] + 1;
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction : xs

  // Expected edge count behind a selector code; kind 0 pll, 1 usb, 2 main
  function automatic int exp_e(input int kind, input int code, input int pcode);
    int map[3][4] = '{'{0, 1, -1, 3}, '{0, 1, -1, -1}, '{0, 9, 2, 4}};
    int s;
    s = map[kind][code];
    if (s == 9)
      s = map[0][pcode];
    return (s < 0) ? 0 : src_e[s];
  endfunction : exp_e

  function automatic logic near(input int a, input int e);
    return (e == 0) ? (a == 0) : (a - e <= 1 && e - a <= 1);
  endfunction : near

  task automatic conclude();
    if (error_cnt == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude

  // One APB transfer; request held until pready is sampled high
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    int n;
    @(posedge sys_clk);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge sys_clk);
    apb.penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      error_cnt++;
      conclude();
    end
    rd = prdata;
    err = pslverr;
    apb.psel <= 1'b0;
    apb.penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    xfer(1'b1, a, d, r, e);
    `CHK("write_err", 1'b0, e)
  endtask : wr

  task automatic rd_chk(input string nm, input logic [31:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    xfer(1'b0, a, 32'h0, r, e);
    `CHK(nm, x, r)
  endtask : rd_chk

  // Zero then one arms a switch; then wait for all selectors to settle
  task automatic upd(input logic [31:0] a);
    logic [31:0] r;
    logic e;
    int n;
    wr(a, 32'h0);
    wr(a, 32'h1);
    n = 0;
    do
    begin
      xfer(1'b0, `CSD_ADDR_STATUS, 32'h0, r, e);
      n++;
    end
    while (r[10:8] !== 3'h0 && n < 100);
    `CHK("switch_settle", 3'h0, r[10:8])
  endtask : upd

  // Count rising edges of sources and outputs over a window
  task automatic measure(input int w);
    logic [4:0] ps;
    logic [3:0] po, co;
    ps = osc_v;
    po = {core_clk, main_clk, usb_ref, spll_ref};
    src_e = '{default: 0};
    out_e = '{default: 0};
    repeat (w)
    begin
      @(posedge sys_clk);
      co = {core_clk, main_clk, usb_ref, spll_ref};
      for (int i = 0; i < 5; i++)
        if (osc_v[i] && !ps[i]) src_e[i]++;
      for (int i = 0; i < 4; i++)
        if (co[i] && !po[i]) out_e[i]++;
      ps = osc_v;
      po = co;
      `CHK("fanout", {core_clk, core_clk}, {periph_clk, mem_clk})
    end
  endtask : measure

  task automatic edge_chk(input string nm, input int k, input int x);
    `CHK(nm, 1'b1, near(out_e[k], x))
  endtask : edge_chk

  // Hang guard
  initial
  begin
    repeat (100000) @(posedge sys_clk);
    error_cnt++;
    conclude();
  end

  initial
  begin
    logic [31:0] r;
    logic e;
    int k;
    int rat[9];
    rat = '{0, 1, 2, 3, 7, 255, 0, 0, 0};
    rst_n = 1'b0;
    clk_en = 1'b1;
    apb = '0;
    osc_v = 5'h0;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    // Reset values, then an unmapped place
    for (int i = 0; i < 7; i++)
      rd_chk("reset_value", addrs[i], rstv[i]);
    xfer(1'b0, 32'h40048050, 32'h0, r, e);
    `CHK("unmapped_err", 1'b1, e)
    `CHK("unmapped_data", 32'h0, r)
    // Random readback of choice and ratio fields; no update strobe touched
    for (int i = 0; i < 8; i++)
    begin
      seed = xs(seed);
      k = 2 * int'(seed[1:0]);
      wr(addrs[k], seed);
      rd_chk("readback", addrs[k], seed & mask[k]);
    end
    // Pll source codes, seen on the pll reference and through main's pll input
    wr(`CSD_ADDR_RATIO, 32'h1);
    wr(`CSD_ADDR_MAIN_SEL, 32'h1);
    upd(`CSD_ADDR_MAIN_UPD);
    for (int c = 0; c < 4; c++)
    begin
      wr(`CSD_ADDR_SPLL_SEL, c);
      upd(`CSD_ADDR_SPLL_UPD);
      measure(300);
      edge_chk("pll_ref", 0, exp_e(0, c, c));
      edge_chk("main_pll_in", 2, exp_e(0, c, c));
      edge_chk("core_div1", 3, exp_e(0, c, c));
    end
    // Usb and main source codes; pll stays on the 32 kHz code
    for (int c = 0; c < 4; c++)
    begin
      wr(`CSD_ADDR_USB_SEL, c);
      upd(`CSD_ADDR_USB_UPD);
      wr(`CSD_ADDR_MAIN_SEL, c);
      upd(`CSD_ADDR_MAIN_UPD);
      measure(300);
      edge_chk("usb_ref", 1, exp_e(1, c, 3));
      edge_chk("main_clk", 2, exp_e(2, c, 3));
    end
    // New choices without a zero-then-one strobe must not switch
    wr(`CSD_ADDR_SPLL_SEL, 32'h0);
    wr(`CSD_ADDR_USB_SEL, 32'h1);
    wr(`CSD_ADDR_MAIN_SEL, 32'h0);
    wr(`CSD_ADDR_SPLL_UPD, 32'h1);
    wr(`CSD_ADDR_MAIN_UPD, 32'h0);
    measure(300);
    edge_chk("pll_hold", 0, exp_e(0, 3, 3));
    edge_chk("usb_hold", 1, exp_e(1, 3, 3));
    edge_chk("main_hold", 2, exp_e(2, 3, 3));
    upd(`CSD_ADDR_MAIN_UPD);
    measure(300);
    edge_chk("main_after_strobe", 2, exp_e(2, 0, 0));
    // Divider over the internal oscillator, corner and random ratios
    for (int i = 6; i < 9; i++)
    begin
      seed = xs(seed);
      rat[i] = int'(seed[3:0] % 4'hf) + 1;
    end
    for (int i = 0; i < 9; i++)
    begin
      wr(`CSD_ADDR_RATIO, rat[i]);
      // Let the write reach the divider output before counting
      repeat (2) @(posedge sys_clk);
      measure(600);
      edge_chk("core_div", 3, (rat[i] == 0) ? 0 : (src_e[0] + rat[i] - 1) / rat[i]);
    end
    // Enable low freezes every clock output
    clk_en <= 1'b0;
    @(posedge sys_clk);
    measure(50);
    for (int i = 0; i < 4; i++)
      `CHK("enable_freeze", 0, out_e[i])
    clk_en <= 1'b1;
    conclude();
  end
endmodule : csd_clock_control_tb_top
`default_nettype wire
